// ---- rtl/sadc_consts.vh ----
// Purpose: constants for the converter sequencer
// Assumes: 8-bit register port, 200 MHz system clock
// Notes:   offsets are register indexes on the plain port
`ifndef SADC_CONSTS_VH
`define SADC_CONSTS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SADC_OFF_CTRL0    4'h0
`define SADC_OFF_CTRL1    4'h1
`define SADC_OFF_RES_HI   4'h2
`define SADC_OFF_RES_LO   4'h3
`define SADC_OFF_TRIG     4'h4
`define SADC_OFF_FLAG     4'h5

// ----------------------------------------
// field positions
// ----------------------------------------
`define SADC_C0_EN        0
`define SADC_C0_GO        1
`define SADC_C0_CHS_LO    2
`define SADC_C1_PREF_LO   0
`define SADC_C1_NREF      2
`define SADC_C1_CS_LO     4
`define SADC_C1_FM        7
`define SADC_FL_DONE      0
`define SADC_FL_IE        1

// ----------------------------------------
// reset values
// ----------------------------------------
`define SADC_RST_CHS      6'h00
`define SADC_RST_CS       3'h0
`define SADC_RST_PREF     2'h0
`define SADC_RST_TRIG     5'h00
`define SADC_RST_RES      8'h00

// ----------------------------------------
// timing counts
// ----------------------------------------
`define SADC_TAD_LAST     4'hb
`define SADC_INSTR_CYC    3'h4
`define SADC_DIV2_TOP     6'h01
`define SADC_DIV4_TOP     6'h03
`define SADC_DIV8_TOP     6'h07
`define SADC_DIV16_TOP    6'h0f
`define SADC_DIV32_TOP    6'h1f
`define SADC_DIV64_TOP    6'h3f
`define SADC_MSB_TRIAL    10'h200
`define SADC_TRIG_SRCS    17

`endif

// ---- rtl/sadc_sequencer.v ----
// Purpose: sequencing logic of a 10-bit successive-approximation converter
// Assumes: all inputs synchronous to clk_sys, rc_clk_in sampled as a level
// Notes:   analog side is a comparator input and a trial code output
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "sadc_consts.vh"

module sadc_sequencer (
    input  wire        clk_sys,
    input  wire        rst,
    input  wire [3:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output wire [7:0]  reg_rdata,
    input  wire        cmp_in,
    input  wire        rc_clk_in,
    input  wire        sleep_in,
    input  wire        periph_irq_en,
    input  wire        global_irq_en,
    input  wire [16:0] trig_src,
    output wire [5:0]  chan_sel,
    output wire [1:0]  pos_ref_sel,
    output wire        neg_ref_sel,
    output wire [9:0]  dac_trial,
    output wire        sample_hold,
    output wire        conv_power,
    output wire        wake_pulse,
    output wire        irq_vector
);

// ----------------------------------------
// states
// ----------------------------------------
localparam ST_IDLE  = 2'd0;
localparam ST_DELAY = 2'd1;
localparam ST_CONV  = 2'd2;

// ----------------------------------------
// registers
// ----------------------------------------
reg [1:0] state_reg, state_next;
reg [5:0] chs_reg, chs_next;
reg       en_reg, en_next;
reg       fm_reg, fm_next;
reg [2:0] cs_reg, cs_next;
reg       nref_reg, nref_next;
reg [1:0] pref_reg, pref_next;
reg [4:0] trig_reg, trig_next;
reg       flag_reg, flag_next;
reg       ie_reg, ie_next;
reg [7:0] rhi_reg, rhi_next;
reg [7:0] rlo_reg, rlo_next;
reg [9:0] sar_reg, sar_next;
reg [9:0] trial_reg, trial_next;
reg [9:0] mask_reg, mask_next;
reg       last_reg, last_next;
reg [3:0] tad_reg, tad_next;
reg [5:0] div_reg, div_next;
reg [2:0] dly_reg, dly_next;
reg       pwroff_reg, pwroff_next;
reg       rc_prev_reg;
reg       slp_prev_reg;
reg       tprev_reg;
reg [7:0] rdata_reg, rdata_next;
reg       sh_reg;
reg       pwr_reg;
reg       wake_reg;
reg       vec_reg;

// ----------------------------------------
// decode and helpers
// ----------------------------------------
wire wr0 = reg_wr & (reg_addr == `SADC_OFF_CTRL0);
wire wr1 = reg_wr & (reg_addr == `SADC_OFF_CTRL1);
wire wrt = reg_wr & (reg_addr == `SADC_OFF_TRIG);
wire wrf = reg_wr & (reg_addr == `SADC_OFF_FLAG);

wire busy   = (state_reg != ST_IDLE);
wire use_rc = (cs_reg[1:0] == 2'b11);
wire rc_tick = rc_clk_in & ~rc_prev_reg;
wire slp_enter = sleep_in & ~slp_prev_reg;

// divider terminal count per clock select
reg [5:0] div_top;
always @* begin
    case (cs_reg)
        3'b000:  div_top = `SADC_DIV2_TOP;
        3'b100:  div_top = `SADC_DIV4_TOP;
        3'b001:  div_top = `SADC_DIV8_TOP;
        3'b101:  div_top = `SADC_DIV16_TOP;
        3'b010:  div_top = `SADC_DIV32_TOP;
        3'b110:  div_top = `SADC_DIV64_TOP;
        default: div_top = `SADC_DIV64_TOP;
    endcase
end

wire tad_tick = use_rc ? rc_tick : (div_reg == div_top);

// trigger select: code 0 is no source, 1..17 pick a source
reg trig_now;
always @* begin
    trig_now = 1'b0;
    if ((trig_reg != 5'h00) && (trig_reg <= 5'h11)) begin
        trig_now = trig_src[trig_reg - 5'h01];
    end
end
wire trig_edge = trig_now & ~tprev_reg;

// ----------------------------------------
// partial result fill
// ----------------------------------------
// unresolved bits copy the last resolved bit; after a full run the
// mask is empty, so the same path serves completion and abort
wire [9:0] fill;
genvar gi;
generate
    for (gi = 0; gi < 10; gi = gi + 1) begin : g_fill
        assign fill[gi] = mask_reg[gi] ? last_reg : sar_reg[gi];
    end
endgenerate

// ----------------------------------------
// start, abort and sequencing
// ----------------------------------------
// starts are refused while powered down in sleep, and a go in the
// same write as enable is refused because the old enable is read
wire ok_start = ~busy & en_reg & ~pwroff_reg;
wire sw_start = wr0 & reg_wdata[`SADC_C0_GO] & ok_start;
wire hw_start = trig_edge & ~sleep_in & ok_start;
wire sw_abort = wr0 & ~reg_wdata[`SADC_C0_GO] & busy;
wire kill     = busy & ((wr0 & ~reg_wdata[`SADC_C0_EN])
                | (slp_enter & ~use_rc));

reg complete;
reg load_res;
always @* begin
    state_next = state_reg;
    sar_next   = sar_reg;
    trial_next = trial_reg;
    mask_next  = mask_reg;
    last_next  = last_reg;
    tad_next   = tad_reg;
    dly_next   = dly_reg;
    div_next   = (tad_tick | ~busy) ? 6'h00 : div_reg + 6'h01;
    complete   = 1'b0;
    load_res   = 1'b0;
    case (state_reg)
        ST_IDLE: begin
            if (sw_start | hw_start) begin
                sar_next   = 10'h000;
                trial_next = 10'h000;
                mask_next  = 10'h3ff;
                last_next  = 1'b0;
                tad_next   = 4'h0;
                dly_next   = `SADC_INSTR_CYC - 3'h1;
                state_next = use_rc ? ST_DELAY : ST_CONV;
            end
        end
        ST_DELAY: begin
            // one instruction cycle so a sleep can be issued first
            div_next = 6'h00;
            if (dly_reg == 3'h0) begin
                state_next = ST_CONV;
            end else begin
                dly_next = dly_reg - 3'h1;
            end
        end
        ST_CONV: begin
            if (tad_tick) begin
                tad_next = tad_reg + 4'h1;
                if (tad_reg == 4'h0) begin
                    trial_next = `SADC_MSB_TRIAL;
                    sar_next   = `SADC_MSB_TRIAL;
                end else if (tad_reg == `SADC_TAD_LAST) begin
                    complete   = 1'b1;
                    load_res   = 1'b1;
                    state_next = ST_IDLE;
                end else begin
                    // keep or drop the trial bit, then try the next one
                    sar_next   = (cmp_in ? sar_reg : (sar_reg & ~trial_reg))
                                 | (trial_reg >> 1);
                    last_next  = cmp_in;
                    mask_next  = mask_reg & ~trial_reg;
                    trial_next = trial_reg >> 1;
                end
            end
        end
        default: begin
            state_next = ST_IDLE;
        end
    endcase
    // aborts outrank sequencing; a kill leaves the results alone
    if (kill) begin
        state_next = ST_IDLE;
        complete   = 1'b0;
        load_res   = 1'b0;
    end else if (sw_abort) begin
        state_next = ST_IDLE;
        complete   = 1'b0;
        load_res   = 1'b1;
    end
end

// ----------------------------------------
// software registers and flags
// ----------------------------------------
always @* begin
    chs_next  = chs_reg;
    en_next   = en_reg;
    fm_next   = fm_reg;
    cs_next   = cs_reg;
    nref_next = nref_reg;
    pref_next = pref_reg;
    trig_next = trig_reg;
    ie_next   = ie_reg;
    rhi_next  = rhi_reg;
    rlo_next  = rlo_reg;
    if (wr0) begin
        chs_next = reg_wdata[7:`SADC_C0_CHS_LO];
        en_next  = reg_wdata[`SADC_C0_EN];
    end
    if (wr1) begin
        fm_next   = reg_wdata[`SADC_C1_FM];
        cs_next   = reg_wdata[`SADC_C1_CS_LO+2:`SADC_C1_CS_LO];
        nref_next = reg_wdata[`SADC_C1_NREF];
        pref_next = reg_wdata[`SADC_C1_PREF_LO+1:`SADC_C1_PREF_LO];
    end
    if (wrt) begin
        trig_next = reg_wdata[4:0];
    end
    if (wrf) begin
        ie_next = reg_wdata[`SADC_FL_IE];
    end
    if (load_res) begin
        if (fm_reg) begin
            rhi_next = {6'h00, fill[9:8]};
            rlo_next = fill[7:0];
        end else begin
            rhi_next = fill[9:2];
            rlo_next = {fill[1:0], 6'h00};
        end
    end
    // a completion in the clearing cycle keeps the flag set
    flag_next = complete
                | (flag_reg & ~(wrf & ~reg_wdata[`SADC_FL_DONE]));
end

// ----------------------------------------
// sleep power control
// ----------------------------------------
always @* begin
    pwroff_next = pwroff_reg;
    if (~sleep_in) begin
        pwroff_next = 1'b0;
    end else if (slp_enter & ~use_rc) begin
        pwroff_next = 1'b1;
    end else if (complete & use_rc & ~ie_reg) begin
        pwroff_next = 1'b1;
    end
end

// ----------------------------------------
// read port
// ----------------------------------------
always @* begin
    rdata_next = 8'h00;
    if (reg_rd) begin
        case (reg_addr)
            `SADC_OFF_CTRL0:  rdata_next = {chs_reg, busy, en_reg};
            `SADC_OFF_CTRL1:  rdata_next = {fm_reg, cs_reg, 1'b0,
                                            nref_reg, pref_reg};
            `SADC_OFF_RES_HI: rdata_next = rhi_reg;
            `SADC_OFF_RES_LO: rdata_next = rlo_reg;
            `SADC_OFF_TRIG:   rdata_next = {3'h0, trig_reg};
            `SADC_OFF_FLAG:   rdata_next = {6'h00, ie_reg, flag_reg};
            default:          rdata_next = 8'h00;
        endcase
    end
end

// ----------------------------------------
// state update
// ----------------------------------------
// reset puts every register in its idle value and stops any run
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        state_reg    <= ST_IDLE;
        chs_reg      <= `SADC_RST_CHS;
        en_reg       <= 1'b0;
        fm_reg       <= 1'b0;
        cs_reg       <= `SADC_RST_CS;
        nref_reg     <= 1'b0;
        pref_reg     <= `SADC_RST_PREF;
        trig_reg     <= `SADC_RST_TRIG;
        flag_reg     <= 1'b0;
        ie_reg       <= 1'b0;
        rhi_reg      <= `SADC_RST_RES;
        rlo_reg      <= `SADC_RST_RES;
        sar_reg      <= 10'h000;
        trial_reg    <= 10'h000;
        mask_reg     <= 10'h3ff;
        last_reg     <= 1'b0;
        tad_reg      <= 4'h0;
        div_reg      <= 6'h00;
        dly_reg      <= 3'h0;
        pwroff_reg   <= 1'b0;
        rc_prev_reg  <= 1'b0;
        slp_prev_reg <= 1'b0;
        tprev_reg    <= 1'b0;
        rdata_reg    <= 8'h00;
        sh_reg       <= 1'b1;
        pwr_reg      <= 1'b0;
        wake_reg     <= 1'b0;
        vec_reg      <= 1'b0;
    end else begin
        state_reg    <= state_next;
        chs_reg      <= chs_next;
        en_reg       <= en_next;
        fm_reg       <= fm_next;
        cs_reg       <= cs_next;
        nref_reg     <= nref_next;
        pref_reg     <= pref_next;
        trig_reg     <= trig_next;
        flag_reg     <= flag_next;
        ie_reg       <= ie_next;
        rhi_reg      <= rhi_next;
        rlo_reg      <= rlo_next;
        sar_reg      <= sar_next;
        trial_reg    <= trial_next;
        mask_reg     <= mask_next;
        last_reg     <= last_next;
        tad_reg      <= tad_next;
        div_reg      <= div_next;
        dly_reg      <= dly_next;
        pwroff_reg   <= pwroff_next;
        rc_prev_reg  <= rc_clk_in;
        slp_prev_reg <= sleep_in;
        tprev_reg    <= trig_now;
        rdata_reg    <= rdata_next;
        sh_reg       <= (state_next != ST_CONV);
        pwr_reg      <= en_next & ~pwroff_next;
        wake_reg     <= complete & ie_reg & sleep_in;
        vec_reg      <= flag_next & ie_next & periph_irq_en
                        & global_irq_en;
    end
end

// ----------------------------------------
// outputs
// ----------------------------------------
assign reg_rdata   = rdata_reg;
assign chan_sel    = chs_reg;
assign pos_ref_sel = pref_reg;
assign neg_ref_sel = nref_reg;
assign dac_trial   = sar_reg;
assign sample_hold = sh_reg;
assign conv_power  = pwr_reg;
assign wake_pulse  = wake_reg;
assign irq_vector  = vec_reg;

endmodule // sadc_sequencer

// ---- tb/sadc_analog_model.sv ----
// Purpose: analog source and rc oscillator beside the sequencer
// Assumes: comparator follows the trial code at once
// Notes:   rc clock runs free, one rise per six system clocks
`timescale 1ns/1ps
module sadc_analog_model (
    input  wire       clk_sys,
    input  wire       rst,
    input  wire [9:0] level,
    input  wire [9:0] dac_trial,
    input  wire       conv_power,
    output reg        cmp_in,
    output reg        rc_clk_in
);
    reg [2:0] rc_cnt_reg;
    reg       junk_reg;
    // ------
    // source
    // ------
    // unpowered comparator gives no answer worth trusting, so it chatters
    always @* begin
        cmp_in = conv_power ? (level >= dac_trial) : junk_reg;
    end
    // oscillator: three clocks high, three low
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rc_cnt_reg <= 3'h0;
            rc_clk_in  <= 1'b0;
            junk_reg   <= 1'b0;
        end else begin
            junk_reg   <= ~junk_reg;
            rc_cnt_reg <= (rc_cnt_reg == 3'h2) ? 3'h0 : rc_cnt_reg + 3'h1;
            if (rc_cnt_reg == 3'h2) begin
                rc_clk_in <= ~rc_clk_in;
            end
        end
    end
endmodule // sadc_analog_model

// ---- tb/sadc_asserts.sv ----
// Purpose: port relations of the converter sequencer
// Assumes: one clock, asynchronous active-high reset
// Notes:   sees only the top ports, bound below
`timescale 1ns/1ps
`include "sadc_consts.vh"
module sadc_asserts (
    input wire       clk_sys,
    input wire       rst,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       sleep_in,
    input wire       periph_irq_en,
    input wire       global_irq_en,
    input wire [5:0] chan_sel,
    input wire [1:0] pos_ref_sel,
    input wire       neg_ref_sel,
    input wire       sample_hold,
    input wire       conv_power,
    input wire       wake_pulse,
    input wire       irq_vector
);
    // ------
    // checks
    // ------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // a write to the first control register
    sequence s_c0_wr;
        reg_wr && reg_addr == `SADC_OFF_CTRL0;
    endsequence
    // nothing that could cut a run short
    sequence s_calm;
        !reg_wr && !sleep_in;
    endsequence
    property p_chan_wr;
        s_c0_wr |=> chan_sel == $past(reg_wdata[7:2]);
    endproperty
    a_chan_wr: assert property (p_chan_wr) else $error("channel not taken");
    property p_chan_src;
        $changed(chan_sel) |-> $past(reg_wr) && $past(reg_addr) == `SADC_OFF_CTRL0;
    endproperty
    a_chan_src: assert property (p_chan_src) else $error("channel moved alone");
    property p_refs;
        reg_wr && reg_addr == `SADC_OFF_CTRL1 |=> pos_ref_sel == $past(reg_wdata[1:0])
            && neg_ref_sel == $past(reg_wdata[2]);
    endproperty
    a_refs: assert property (p_refs) else $error("reference select wrong");
    property p_start;
        s_c0_wr ##0 (reg_wdata[1:0] == 2'b11 && conv_power && sample_hold && !sleep_in)
            |-> ##[1:8] !sample_hold;
    endproperty
    a_start: assert property (p_start) else $error("go did not start");
    property p_conv_min;
        ($fell(sample_hold) && !reg_wr && !sleep_in) ##1 s_calm [*7] |-> !sample_hold;
    endproperty
    a_conv_min: assert property (p_conv_min) else $error("conversion too short");
    property p_power_off;
        s_c0_wr ##0 !reg_wdata[0] |-> ##[1:2] !conv_power;
    endproperty
    a_power_off: assert property (p_power_off) else $error("power stayed on");
    property p_wake_one;
        wake_pulse |=> !wake_pulse;
    endproperty
    a_wake_one: assert property (p_wake_one) else $error("wake too long");
    property p_vector;
        irq_vector |-> $past(periph_irq_en) && $past(global_irq_en);
    endproperty
    a_vector: assert property (p_vector) else $error("vector without enables");
endmodule // sadc_asserts

bind sadc_sequencer sadc_asserts i_chk (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .sleep_in(sleep_in), .periph_irq_en(periph_irq_en),
    .global_irq_en(global_irq_en), .chan_sel(chan_sel), .pos_ref_sel(pos_ref_sel),
    .neg_ref_sel(neg_ref_sel), .sample_hold(sample_hold), .conv_power(conv_power),
    .wake_pulse(wake_pulse), .irq_vector(irq_vector)
);

// ---- tb/sadc_sequencer_tb.sv ----
// Purpose: self-checking bench for the converter sequencer
// Assumes: 200 MHz clock, reads answer one cycle later
// Notes:   levels, formats and fields drawn from a fixed seed
`timescale 1ns/1ps
module sadc_sequencer_tb;
    reg         clk_sys = 1'b0;
    reg         rst = 1'b1;
    reg  [3:0]  reg_addr = 4'h0;
    reg  [7:0]  reg_wdata = 8'h00;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    reg         sleep_in = 1'b0;
    reg         periph_irq_en = 1'b0;
    reg         global_irq_en = 1'b0;
    reg  [16:0] trig_src = 17'h00000;
    reg  [9:0]  level = 10'h000;
    wire [7:0]  reg_rdata;
    wire [5:0]  chan_sel;
    wire [1:0]  pos_ref_sel;
    wire [9:0]  dac_trial;
    wire        neg_ref_sel, cmp_in, rc_clk_in, sample_hold;
    wire        conv_power, wake_pulse, irq_vector;
    integer     mismatches = 0;
    integer     checked = 0;
    integer     seed = 32'h3b82;
    integer     n, k;
    reg  [7:0]  rd_val, c1;
    reg  [9:0]  lv;

    sadc_sequencer i_dut (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_in(cmp_in),
        .rc_clk_in(rc_clk_in), .sleep_in(sleep_in), .periph_irq_en(periph_irq_en),
        .global_irq_en(global_irq_en), .trig_src(trig_src), .chan_sel(chan_sel),
        .pos_ref_sel(pos_ref_sel), .neg_ref_sel(neg_ref_sel), .dac_trial(dac_trial),
        .sample_hold(sample_hold), .conv_power(conv_power), .wake_pulse(wake_pulse),
        .irq_vector(irq_vector)
    );
    sadc_analog_model i_src (
        .clk_sys(clk_sys), .rst(rst), .level(level), .dac_trial(dac_trial),
        .conv_power(conv_power), .cmp_in(cmp_in), .rc_clk_in(rc_clk_in)
    );
    // ------
    // helpers
    // ------
    always #2.5 clk_sys = ~clk_sys;
    // result pair as one word: justify bit high puts the six zeros on top
    function [15:0] fmt(input fm, input [9:0] r);
        fmt = fm ? {6'h00, r} : {r, 6'h00};
    endfunction
    function integer divn(input [2:0] c);
        divn = 2 << {c[1], c[0], c[2]};
    endfunction
    task give_verdict;
        begin
            $display("comparisons %0d mismatches %0d", checked, mismatches);
            if (mismatches == 0 && checked > 0) begin
                $display("Testbench passed");
            end else begin
                $display("Testbench failed");
            end
            $finish;
        end
    endtask
    task check(input [15:0] seen, input [15:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task tick(input integer c);
        begin
            repeat (c) @(posedge clk_sys);
            #1;
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge clk_sys);
            reg_addr  <= a;
            reg_wdata <= d;
            reg_wr    <= 1'b1;
            tick(1);
            reg_wr    <= 1'b0;
        end
    endtask
    task rd(input [3:0] a);
        begin
            @(posedge clk_sys);
            reg_addr <= a;
            reg_rd   <= 1'b1;
            tick(1);
            reg_rd   <= 1'b0;
            // read data stand only in the cycle after the strobe
            rd_val = reg_rdata;
            tick(1);
        end
    endtask
    // counts edges after the start edge until tracking resumes; the first
    // six are always waited so the rc start delay is not taken for idle
    task wait_idle;
        begin
            for (n = 0; n < 6 || (!sample_hold && n < 1000); n = n + 1) tick(1);
            if (n >= 1000) begin
                mismatches = mismatches + 1;
                give_verdict;
            end
        end
    endtask
    task conv(input [2:0] cs, input fm, input [9:0] v);
        begin
            level <= v;
            c1 = $random(seed);
            c1[7:4] = {fm, cs};
            wr(4'h1, c1);
            check(pos_ref_sel, c1[1:0]);
            check(neg_ref_sel, c1[2]);
            rd(4'h1);
            check(rd_val, c1 & 8'hf7);
            wr(4'h0, 8'hf1);
            wr(4'h0, {c1[5:0], 2'b01});
            check(chan_sel, c1[5:0]);
            wr(4'h5, 8'h00);
            tick(20);
            wr(4'h0, {c1[5:0], 2'b11});
            wait_idle;
            if (cs[1:0] != 2'b11) check(n, 12 * divn(cs));
            rd(4'h0);
            check(rd_val[1:0], 2'b01);
            rd(4'h2);
            check(rd_val, fmt(fm, v) >> 8);
            rd(4'h3);
            check(rd_val, fmt(fm, v) & 16'h00ff);
            rd(4'h5);
            check(rd_val[0], 1'b1);
        end
    endtask
    // ------
    // sequence
    // ------
    initial begin
        tick(4);
        rst <= 1'b0;
        for (k = 0; k < 7; k = k + 1) begin
            rd(k == 6 ? 4'hf : k[3:0]);
            check(rd_val, 8'h00);
        end
        wr(4'h0, 8'h03);
        tick(4);
        check(sample_hold, 1'b1);
        for (k = 0; k < 8; k = k + 1) begin
            lv = $random(seed);
            conv(k[2:0], lv[0], lv);
        end
        conv(3'h4, 1'b0, 10'h000);
        conv(3'h0, 1'b1, 10'h3ff);
        wr(4'h5, 8'h00);
        rd(4'h5);
        check(rd_val, 8'h00);
        rd(4'h2);
        check(rd_val, 8'h03);
        // abort a full-scale run part way: filled bits copy the last one
        wr(4'h1, 8'h00);
        level <= 10'h3ff;
        wr(4'h0, 8'h03);
        tick(12);
        wr(4'h0, 8'h01);
        rd(4'h3);
        check(rd_val, 8'hc0);
        rd(4'h5);
        check(rd_val[0], 1'b0);
        // sleep on a divided clock, with a trigger that must be ignored
        wr(4'h0, 8'h03);
        tick(6);
        sleep_in <= 1'b1;
        tick(4);
        check({conv_power, sample_hold}, 2'b01);
        rd(4'h0);
        check(rd_val[0], 1'b1);
        wr(4'h4, 8'h01);
        trig_src <= 17'h00001;
        tick(4);
        check(sample_hold, 1'b1);
        trig_src <= 17'h00000;
        sleep_in <= 1'b0;
        tick(3);
        check(conv_power, 1'b1);
        for (k = 0; k < 17; k = k + 1) begin
            wr(4'h4, k[7:0] + 8'h01);
            trig_src <= 17'h00001 << k;
            tick(3);
            check(sample_hold, 1'b0);
            trig_src <= 17'h00000;
            wait_idle;
        end
        // clearing the enable powers the converter down
        wr(4'h0, 8'h00);
        check(conv_power, 1'b0);
        wr(4'h0, 8'h01);
        // rc clock: sleep in the start delay, completion wakes
        wr(4'h1, 8'h30);
        wr(4'h5, 8'h02);
        periph_irq_en <= 1'b1;
        global_irq_en <= 1'b1;
        level <= 10'h155;
        wr(4'h0, 8'h03);
        check(sample_hold, 1'b1);
        sleep_in <= 1'b1;
        for (k = 0; k < 200 && wake_pulse !== 1'b1; k = k + 1) tick(1);
        check(wake_pulse, 1'b1);
        tick(2);
        check(irq_vector, 1'b1);
        sleep_in <= 1'b0;
        wr(4'h5, 8'h00);
        wr(4'h0, 8'h03);
        sleep_in <= 1'b1;
        tick(120);
        check(conv_power, 1'b0);
        rd(4'h0);
        check(rd_val[1:0], 2'b01);
        sleep_in <= 1'b0;
        wr(4'h0, 8'h03);
        tick(5);
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        check({conv_power, sample_hold, irq_vector}, 3'b010);
        rd(4'h1);
        check(rd_val, 8'h00);
        give_verdict;
    end
endmodule // sadc_sequencer_tb
